//--- src/hti_readout.sv
// Two-wire slave readout with measurement sequencer for humidity and temperature.
`timescale 1ns/10ps
module hti_readout
  import hti_pkg::*;
#(
  parameter int WAKE_CYC   = WAKE_CYCLES,
  parameter int CONV8_CYC  = CONV8_CYCLES,
  parameter int CONV10_CYC = CONV10_CYCLES,
  parameter int CONV12_CYC = CONV12_CYCLES,
  parameter int CONV14_CYC = CONV14_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        link_clock,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [1:0]  hum_res,
  input  wire logic [1:0]  temp_res,
  input  wire logic [13:0] hum_sample,
  input  wire logic [13:0] temp_sample,
  output logic             core_awake
);

  // Link domain state.
  hti_link_e       ls_reg, ls_next;
  logic [3:0]      cnt_reg, cnt_next;
  logic [7:0]      sh_reg, sh_next;
  logic [1:0]      idx_reg, idx_next;
  logic [1:0]      stat_reg, stat_next;
  logic            valid_reg, valid_next;
  logic            req_tgl_reg, req_tgl_next;
  hti_result_s     lres_reg, lres_next;
  logic            fetch_hit;
  logic            scl_s1, scl_s2, scl_d;
  logic            sda_s1, sda_s2, sda_d;
  logic            done_s1, done_s2, done_s3;
  logic            scl_rise, scl_fall, start_evt, stop_evt, done_evt;

  // Core domain state.
  hti_core_e       cs_reg, cs_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [13:0]     hum_p_reg, hum_p_next;
  logic [13:0]     temp_p_reg, temp_p_next;
  hti_result_s     cres_reg, cres_next;
  logic            done_tgl_reg, done_tgl_next;
  logic            awake_reg, awake_next;
  logic            req_s1, req_s2, req_s3;
  logic            req_evt;

  function automatic logic [7:0] byte_of(input logic [1:0] idx, input logic [1:0] st,
                                         input hti_result_s r);
    case (idx)
      2'h0:    byte_of = {st, r.hum[13:8]};
      2'h1:    byte_of = r.hum[7:0];
      2'h2:    byte_of = r.temp[13:6];
      default: byte_of = {r.temp[5:0], 2'h0};
    endcase
  endfunction

  function automatic logic [TMR_W-1:0] conv_load(input logic [1:0] res);
    case (res)
      RES_8:   conv_load = TMR_W'(CONV8_CYC - 1);
      RES_10:  conv_load = TMR_W'(CONV10_CYC - 1);
      RES_12:  conv_load = TMR_W'(CONV12_CYC - 1);
      default: conv_load = TMR_W'(CONV14_CYC - 1);
    endcase
  endfunction

  // Pins and the core's done toggle enter the link domain through two flops.
  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_s1  <= 1'b1;
      scl_s2  <= 1'b1;
      scl_d   <= 1'b1;
      sda_s1  <= 1'b1;
      sda_s2  <= 1'b1;
      sda_d   <= 1'b1;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
    end else begin
      scl_s1  <= scl_in;
      scl_s2  <= scl_s1;
      scl_d   <= scl_s2;
      sda_s1  <= sda_in;
      sda_s2  <= sda_s1;
      sda_d   <= sda_s2;
      done_s1 <= done_tgl_reg;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
    end
  end

  assign scl_rise  = scl_s2 & ~scl_d;
  assign scl_fall  = ~scl_s2 & scl_d;
  assign start_evt = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_evt  = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign done_evt  = done_s2 ^ done_s3;

  always_comb begin
    ls_next      = ls_reg;
    cnt_next     = cnt_reg;
    sh_next      = sh_reg;
    idx_next     = idx_reg;
    stat_next    = stat_reg;
    req_tgl_next = req_tgl_reg;
    lres_next    = lres_reg;
    fetch_hit    = 1'b0;
    if (done_evt) begin
      lres_next = cres_reg;
    end
    if (start_evt) begin
      ls_next  = LS_ADDR;
      cnt_next = 4'h0;
    end else if (stop_evt) begin
      ls_next = LS_IDLE;
    end else begin
      case (ls_reg)
        LS_ADDR: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_s2};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == BYTE_BITS) begin
            ls_next = (sh_reg[7:1] == SLAVE_ADDR) ? LS_ACKA : LS_SKIP;
          end
        end
        LS_ACKA: begin
          if (scl_fall) begin
            if (sh_reg[0]) begin
              fetch_hit = 1'b1;
              ls_next   = LS_TX;
              stat_next = valid_reg ? STATUS_VALID : STATUS_STALE;
              idx_next  = 2'h0;
              sh_next   = byte_of(2'h0, stat_next, lres_reg);
              cnt_next  = 4'h0;
            end else begin
              ls_next      = LS_SKIP;
              req_tgl_next = ~req_tgl_reg;
            end
          end
        end
        LS_TX: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == BYTE_BITS) begin
              ls_next = LS_MACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b1};
            end
          end
        end
        LS_MACK: begin
          if (scl_rise && sda_s2) begin
            ls_next = LS_SKIP;
          end else if (scl_fall) begin
            idx_next = idx_reg + 2'h1;
            sh_next  = byte_of(idx_next, stat_reg, lres_reg);
            cnt_next = 4'h0;
            ls_next  = LS_TX;
          end
        end
        LS_IDLE, LS_SKIP: begin
        end
        default: ls_next = LS_IDLE;
      endcase
    end
    // A completed cycle arriving together with a fetch leaves the data valid.
    if (done_evt) begin
      valid_next = 1'b1;
    end else if (fetch_hit) begin
      valid_next = 1'b0;
    end else begin
      valid_next = valid_reg;
    end
  end

  always_ff @(posedge link_clock or negedge reset_n) begin
    if (!reset_n) begin
      ls_reg      <= LS_IDLE;
      cnt_reg     <= 4'h0;
      sh_reg      <= 8'hff;
      idx_reg     <= 2'h0;
      stat_reg    <= STATUS_STALE;
      valid_reg   <= 1'b0;
      req_tgl_reg <= 1'b0;
      lres_reg    <= '0;
    end else begin
      ls_reg      <= ls_next;
      cnt_reg     <= cnt_next;
      sh_reg      <= sh_next;
      idx_reg     <= idx_next;
      stat_reg    <= stat_next;
      valid_reg   <= valid_next;
      req_tgl_reg <= req_tgl_next;
      lres_reg    <= lres_next;
    end
  end

  // Open drain: only ever pull low, during address acknowledge or a zero data bit.
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~((ls_reg == LS_ACKA) || (ls_reg == LS_TX && !sh_reg[7]));

  // Measurement request crosses into the core domain as a toggle.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req_tgl_reg;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  assign req_evt = req_s2 ^ req_s3;

  // Requests arriving while a cycle runs are dropped.
  always_comb begin
    cs_next       = cs_reg;
    tmr_next      = tmr_reg;
    hum_p_next    = hum_p_reg;
    temp_p_next   = temp_p_reg;
    cres_next     = cres_reg;
    done_tgl_next = done_tgl_reg;
    case (cs_reg)
      CS_SLEEP: begin
        if (req_evt) begin
          cs_next  = CS_WAKE;
          tmr_next = TMR_W'(WAKE_CYC - 1);
        end
      end
      CS_WAKE: begin
        if (tmr_reg == '0) begin
          cs_next  = CS_HUM;
          tmr_next = conv_load(hum_res);
        end else begin
          tmr_next = tmr_reg - TMR_W'(1);
        end
      end
      CS_HUM: begin
        if (tmr_reg == '0) begin
          hum_p_next = hum_sample;
          cs_next    = CS_TEMP;
          tmr_next   = conv_load(temp_res);
        end else begin
          tmr_next = tmr_reg - TMR_W'(1);
        end
      end
      CS_TEMP: begin
        if (tmr_reg == '0) begin
          temp_p_next = temp_sample;
          cs_next     = CS_DONE;
        end else begin
          tmr_next = tmr_reg - TMR_W'(1);
        end
      end
      CS_DONE: begin
        cres_next     = '{hum: hum_p_reg, temp: temp_p_reg};
        done_tgl_next = ~done_tgl_reg;
        cs_next       = CS_SLEEP;
      end
      default: cs_next = CS_SLEEP;
    endcase
    awake_next = (cs_next != CS_SLEEP);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cs_reg       <= CS_SLEEP;
      tmr_reg      <= '0;
      hum_p_reg    <= 14'h0;
      temp_p_reg   <= 14'h0;
      cres_reg     <= '0;
      done_tgl_reg <= 1'b0;
      awake_reg    <= 1'b0;
    end else begin
      cs_reg       <= cs_next;
      tmr_reg      <= tmr_next;
      hum_p_reg    <= hum_p_next;
      temp_p_reg   <= temp_p_next;
      cres_reg     <= cres_next;
      done_tgl_reg <= done_tgl_next;
      awake_reg    <= awake_next;
    end
  end

  assign core_awake = awake_reg;

  addr_match_a: assert property (@(posedge link_clock) disable iff (!reset_n)
    ls_reg == LS_ACKA |-> sh_reg[7:1] == SLAVE_ADDR)
    else $error("acknowledge given to a foreign address");

  start_addr_a: assert property (@(posedge link_clock) disable iff (!reset_n)
    start_evt |=> ls_reg == LS_ADDR && cnt_reg == 4'h0)
    else $error("start did not restart address phase");

  stop_idle_a: assert property (@(posedge link_clock) disable iff (!reset_n)
    stop_evt && !start_evt |=> ls_reg == LS_IDLE && sda_oe_n)
    else $error("stop did not release the bus");

  drive_only_a: assert property (@(posedge link_clock) disable iff (!reset_n)
    !sda_oe_n |-> ls_reg inside {LS_ACKA, LS_TX})
    else $error("data line pulled outside acknowledge or transmit");

  msb_first_a: assert property (@(posedge link_clock) disable iff (!reset_n)
    ls_reg == LS_TX && scl_fall && cnt_reg != BYTE_BITS |=> sh_reg[7] == $past(sh_reg[6]))
    else $error("transmit shift order broken");

  req_write_a: assert property (@(posedge link_clock) disable iff (!reset_n)
    $changed(req_tgl_reg) |-> $past(ls_reg == LS_ACKA && !sh_reg[0] && scl_fall))
    else $error("measurement request raised outside write address");

  stale_fetch_a: assert property (@(posedge link_clock) disable iff (!reset_n)
    fetch_hit && !done_evt |=> !valid_reg ##0 stat_reg == $past(valid_reg ? 2'h0 : 2'h1))
    else $error("fetch did not mark data stale");

  valid_cause_a: assert property (@(posedge link_clock) disable iff (!reset_n)
    $rose(valid_reg) |-> $past(done_evt))
    else $error("status went valid without a completed cycle");

  sleep_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    cs_reg == CS_SLEEP && !req_evt |=> cs_reg == CS_SLEEP && !core_awake)
    else $error("core left sleep without request");

  order_a: assert property (@(posedge clock) disable iff (!reset_n)
    $changed(done_tgl_reg) |-> $past(cs_reg == CS_DONE) && $past(cs_reg, 2) == CS_TEMP)
    else $error("output updated out of order");

  conv_load_a: assert property (@(posedge clock) disable iff (!reset_n)
    cs_reg == CS_WAKE && tmr_reg == '0 |=> cs_reg == CS_HUM && tmr_reg == conv_load(hum_res))
    else $error("humidity conversion time not loaded");

endmodule // hti_readout

//--- common/hti_pkg.sv
// Constants, types and state encodings of the humidity and temperature readout.
package hti_pkg;

  localparam logic [6:0] SLAVE_ADDR     = 7'h44;
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [1:0] STATUS_VALID   = 2'h0;
  localparam logic [1:0] STATUS_STALE   = 2'h1;
  localparam logic [1:0] RES_8          = 2'h0;
  localparam logic [1:0] RES_10         = 2'h1;
  localparam logic [1:0] RES_12         = 2'h2;
  localparam logic [1:0] RES_14         = 2'h3;

  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         WAKE_TIME_NS   = 100000;
  localparam int         CONV8_TIME_NS  = 550000;
  localparam int         CONV10_TIME_NS = 1310000;
  localparam int         CONV12_TIME_NS = 4500000;
  localparam int         CONV14_TIME_NS = 16900000;
  localparam int         WAKE_CYCLES    = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int         CONV8_CYCLES   = CONV8_TIME_NS / CLK_PERIOD_NS;
  localparam int         CONV10_CYCLES  = CONV10_TIME_NS / CLK_PERIOD_NS;
  localparam int         CONV12_CYCLES  = CONV12_TIME_NS / CLK_PERIOD_NS;
  localparam int         CONV14_CYCLES  = CONV14_TIME_NS / CLK_PERIOD_NS;
  localparam int         TMR_W          = 21;

  typedef enum logic [5:0] {
    LS_IDLE = 6'h01,
    LS_ADDR = 6'h02,
    LS_ACKA = 6'h04,
    LS_TX   = 6'h08,
    LS_MACK = 6'h10,
    LS_SKIP = 6'h20
  } hti_link_e;

  typedef enum logic [4:0] {
    CS_SLEEP = 5'h01,
    CS_WAKE  = 5'h02,
    CS_HUM   = 5'h04,
    CS_TEMP  = 5'h08,
    CS_DONE  = 5'h10
  } hti_core_e;

  typedef struct packed {
    logic [13:0] hum;
    logic [13:0] temp;
  } hti_result_s;

endpackage

//--- tb/hti_i2c_master.sv
// Behavioural two-wire bus master that is the only master on the readout's bus.
`timescale 1ns/10ps
module hti_i2c_master #(
  parameter int HALF_NS = 1250
) (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  localparam int Q_NS = HALF_NS / 2;

  // The clock stands high and the data line is released between frames.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic start_bit();
    #Q_NS sda_drv = 1'b1;
    #(HALF_NS - Q_NS) scl = 1'b1;
    #HALF_NS sda_drv = 1'b0;
    #HALF_NS scl = 1'b0;
  endtask

  task automatic stop_bit();
    #Q_NS sda_drv = 1'b0;
    #(HALF_NS - Q_NS) scl = 1'b1;
    #HALF_NS sda_drv = 1'b1;
    #HALF_NS;
  endtask

  // Data changes a quarter period after the fall so it never moves while the clock is high.
  task automatic clock_bit(input logic b, output logic seen);
    #Q_NS sda_drv = b;
    #(HALF_NS - Q_NS) scl = 1'b1;
    #HALF_NS seen = sda_line;
    scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, ack_n);
  endtask

  // A last byte is answered with a release, which ends the fetch.
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(last, s);
  endtask
endmodule  // hti_i2c_master

//--- tb/tb_hti_readout.sv
// Self-checking testbench of the two-wire humidity and temperature readout.
`timescale 1ns/10ps
module tb_hti_readout;
  import hti_pkg::*;
  localparam int W_CYC        = 20;
  localparam int CONV_CYC [4] = '{50, 60, 70, 80};

  logic        clock;
  logic        reset_n;
  logic        link_clock;
  wire logic   scl;
  wire logic   sda_drv;
  wire logic   sda_line;
  logic        sda_out;
  logic        sda_oe_n;
  logic [1:0]  hum_res;
  logic [1:0]  temp_res;
  logic [13:0] hum_sample;
  logic [13:0] temp_sample;
  logic        core_awake;
  int          fail_count;
  int          num_checks;
  int          awake_cnt = 0;
  int          awake_base;
  logic        ack_n;
  logic [7:0]  rx [5];

  // The pull-up wins unless a party pulls the line low.
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  hti_readout #(
    .WAKE_CYC   (W_CYC),
    .CONV8_CYC  (CONV_CYC[0]),
    .CONV10_CYC (CONV_CYC[1]),
    .CONV12_CYC (CONV_CYC[2]),
    .CONV14_CYC (CONV_CYC[3])
  ) i_hti_readout (
    .clock       (clock),
    .reset_n     (reset_n),
    .link_clock  (link_clock),
    .scl_in      (scl),
    .sda_in      (sda_line),
    .sda_out     (sda_out),
    .sda_oe_n    (sda_oe_n),
    .hum_res     (hum_res),
    .temp_res    (temp_res),
    .hum_sample  (hum_sample),
    .temp_sample (temp_sample),
    .core_awake  (core_awake)
  );

  // The bus runs at the fast rate, which also keeps the clock high well above the minimum.
  hti_i2c_master #(.HALF_NS(1250)) i_hti_i2c_master (
    .scl      (scl),
    .sda_drv  (sda_drv),
    .sda_line (sda_line)
  );

  always #5 clock = ~clock;
  always #62.5 link_clock = ~link_clock;
  always @(posedge clock) if (core_awake === 1'b1) awake_cnt <= awake_cnt + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic fetch(input int n);
    i_hti_i2c_master.start_bit();
    i_hti_i2c_master.send_byte({SLAVE_ADDR, 1'b1}, ack_n);
    check(ack_n, 0);
    for (int i = 0; i < n; i++) i_hti_i2c_master.recv_byte(i == n - 1, rx[i]);
    i_hti_i2c_master.stop_bit();
  endtask

  task automatic request(input logic [7:0] addr, input logic exp_ack_n);
    awake_base = awake_cnt;
    i_hti_i2c_master.start_bit();
    i_hti_i2c_master.send_byte(addr, ack_n);
    check(ack_n, exp_ack_n);
    i_hti_i2c_master.stop_bit();
    repeat (300) @(negedge clock);
  endtask

  task automatic test_after_reset();
    check(sda_oe_n, 1);
    check(core_awake, 0);
    fetch(2);
    check(rx[0][7:6], STATUS_STALE);
    check({rx[0][5:0], rx[1]}, 0);
    check(awake_cnt, 0);
  endtask

  task automatic test_foreign();
    request({7'h45, 1'b0}, 1'b1);
    check(awake_cnt - awake_base, 0);
    check(sda_oe_n, 1);
  endtask

  task automatic test_measure(input logic [1:0] code);
    int exp_cyc;
    @(negedge clock);
    hum_res = code;
    temp_res = code + 2'h1;
    hum_sample = 14'h2a5c ^ {12'h0, code};
    temp_sample = 14'h1b37 + {12'h0, code};
    request({SLAVE_ADDR, 1'b0}, 1'b0);
    exp_cyc = W_CYC + CONV_CYC[code] + CONV_CYC[code + 2'h1] + 1;
    check(awake_cnt - awake_base, exp_cyc);
    check(core_awake, 0);
    fetch(5);
    check(rx[0], {STATUS_VALID, hum_sample[13:8]});
    check(rx[1], hum_sample[7:0]);
    check(rx[2], temp_sample[13:6]);
    check(rx[3][7:2], temp_sample[5:0]);
    // The fifth byte wraps to the first and keeps the status taken for this fetch.
    check(rx[4], {STATUS_VALID, hum_sample[13:8]});
    fetch(1);
    check(rx[0], {STATUS_STALE, hum_sample[13:8]});
  endtask

  initial begin
    repeat (115000) @(posedge clock);
    fail_count++;
    complete_run();
  end

  initial begin
    clock = 1'b0;
    link_clock = 1'b0;
    reset_n = 1'b0;
    hum_res = 2'h0;
    temp_res = 2'h0;
    hum_sample = 14'h0;
    temp_sample = 14'h0;
    fail_count = 0;
    num_checks = 0;
    // Reset spans several link clock edges so that both domains are cleared by it.
    repeat (3) @(negedge link_clock);
    @(negedge clock);
    reset_n = 1'b1;
    repeat (5) @(posedge link_clock);
    test_after_reset();
    test_foreign();
    for (int c = 0; c < 4; c++) test_measure(c[1:0]);
    complete_run();
  end
endmodule  // tb_hti_readout
